// ===== common/pirq_pkg.sv
`default_nettype none
package pirq_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_IRQ_CONTROL    = 8'h0B;
    localparam logic [7:0] IDX_EVENT_FLAGS    = 8'h0C;
    localparam logic [7:0] IDX_SECOND_FLAGS   = 8'h0D;
    localparam logic [7:0] IDX_ENABLE_BANK    = 8'h8C;
    localparam logic [7:0] IDX_SECOND_ENABLES = 8'h8D;
    localparam logic [7:0] IDX_RESET_CAUSE    = 8'h8E;

    localparam int BIT_PARALLEL   = 7;
    localparam int BIT_CONVERSION = 6;
    localparam int BIT_RECEIVE    = 5;
    localparam int BIT_TRANSMIT   = 4;
    localparam int BIT_SYNC       = 3;
    localparam int BIT_CCP_ONE    = 2;
    localparam int BIT_TIMER_TWO  = 1;
    localparam int BIT_TIMER_ONE  = 0;
    localparam int BIT_CCP_TWO    = 0;
    localparam int BIT_GLOBAL_EN  = 7;
    localparam int BIT_PERIPH_EN  = 6;
    localparam int BIT_POWER_ON   = 1;
    localparam int BIT_BROWNOUT   = 0;

    // Receive and transmit flags follow the buffers, not software
    localparam logic [7:0] EVENT_WRITE_MASK = 8'hCF;
    localparam logic [7:0] RST_FLAGS        = 8'h00;
    localparam logic [7:0] RST_ENABLES      = 8'h00;
    localparam logic [7:0] RST_RESET_CAUSE  = 8'h01;
    localparam logic [DATA_W-1:0] RD_ZERO   = 32'h0000_0000;

    typedef enum logic [1:0] {
        PIRQ_SSP_SPI        = 2'b00,
        PIRQ_SSP_I2C_SLAVE  = 2'b01,
        PIRQ_SSP_I2C_MASTER = 2'b10,
        PIRQ_SSP_OFF        = 2'b11
    } pirq_ssp_mode_t;

    typedef enum logic [1:0] {
        PIRQ_CCP_OFF     = 2'b00,
        PIRQ_CCP_CAPTURE = 2'b01,
        PIRQ_CCP_COMPARE = 2'b10,
        PIRQ_CCP_PWM     = 2'b11
    } pirq_ccp_mode_t;

    typedef enum logic [0:0] {
        PIRQ_BUS_IDLE   = 1'b0,
        PIRQ_BUS_ANSWER = 1'b1
    } pirq_bus_phase_t;

    typedef struct packed {
        logic           psp_access;
        logic           adc_done;
        logic           rx_buffer_full;
        logic           tx_buffer_empty;
        pirq_ssp_mode_t ssp_mode;
        logic           ssp_xfer_done;
        logic           ssp_seq_done;
        logic           ssp_idle;
        logic           ssp_bus_start;
        logic           ssp_bus_stop;
        pirq_ccp_mode_t capture_compare_one_mode;
        logic           capture_compare_one_capture;
        logic           capture_compare_one_match;
        logic [7:0]     timer_two_count;
        logic [7:0]     period_two;
        logic           timer_one_overflow;
        pirq_ccp_mode_t capture_compare_two_mode;
        logic           capture_compare_two_capture;
        logic           capture_compare_two_match;
        logic           brownout_detected;
        logic           brownout_circuit_enable;
    } pirq_events_t;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [BE_W-1:0]   byteenable;
    } pirq_av_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic              waitrequest;
    } pirq_av_rsp_t;

    typedef struct packed {
        logic [7:0]      event_flags;
        logic [7:0]      second_flags;
        logic [7:0]      enable_bank;
        logic [7:0]      second_enables;
        logic [7:0]      reset_cause;
        logic            global_en;
        logic            periph_en;
        logic            match_seen;
        pirq_bus_phase_t phase;
        pirq_av_rsp_t    rsp;
        logic            irq;
    } pirq_state_t;
endpackage
`default_nettype wire

// ===== rtl/pirq_top.sv
// Contract
// - Event flags set on their event regardless of any enable bit.
// - Event flag register at 0Ch, bits 7..0 parallel down to timer one.
// - Receive and transmit flags are read-only buffer status levels.
// - Parallel flag sets on external port access, held until cleared.
// - Conversion flag sets on conversion done, held until cleared.
// - Serial flag sets on transfer done in SPI and both I2C modes.
// - I2C master: serial flag sets when a started bus sequence completes.
// - Multi-master: START or STOP seen while idle sets serial flag.
// - Capture/compare one flag sets on capture or match, not in PWM.
// - Timer two flag sets when count equals period, held until cleared.
// - Timer one flag sets on overflow, held until cleared.
// - Second enable register at 8Dh: bit 0 only, others read zero.
// - Second flag register at 0Dh: bit 0 capture/compare two event.
// - Capture/compare two flag stays set until software clears it.
// - Reset cause at 8Eh: power-on bit 1, brown-out bit 0.
// - Power-on reset clears power-on bit; software sets it later.
// - Brown-out bit set by software; zero later means brown-out reset.
// - Brown-out bit unreliable when detection circuit is disabled.
// - Peripheral interrupts need the peripheral enable bit set.
// - Enable bank at 8Ch, same bit order as event flags.
//
// The Avalon-MM slave port is this design's own decision.
`default_nettype none
module pirq_top
(
    input  wire logic                   clock,
    input  wire logic                   nrst,
    input  wire pirq_pkg::pirq_events_t events,
    input  wire pirq_pkg::pirq_av_req_t av_req,
    output var  pirq_pkg::pirq_av_rsp_t av_rsp,
    output var  logic                   irq
);
    import pirq_pkg::*;

    pirq_state_t r;
    pirq_state_t next_r;

    logic [7:0] set_one;
    logic       set_two;
    logic       sync_set;
    logic       capture_compare_one_set;
    logic       capture_compare_two_set;
    logic       is_master;
    logic       match_now;
    logic [7:0] index;
    logic       lane0;
    logic       do_write;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic       pending;

    assign av_rsp = r.rsp;
    assign irq    = r.irq;

    always_comb
    begin
        next_r    = r;
        index     = av_req.address[ADDR_W-1:2];
        lane0     = av_req.byteenable[0];
        wbyte     = av_req.writedata[7:0];
        is_master = (events.ssp_mode == PIRQ_SSP_I2C_MASTER);

        // Transfer completion counts in every active serial mode
        sync_set = 1'b0;
        if (events.ssp_mode != PIRQ_SSP_OFF)
        begin
            sync_set = events.ssp_xfer_done;
        end
        if (is_master)
        begin
            sync_set = sync_set | events.ssp_seq_done;
            if (events.ssp_idle)
            begin
                sync_set = sync_set | events.ssp_bus_start
                                    | events.ssp_bus_stop;
            end
        end

        capture_compare_one_set = 1'b0;
        case (events.capture_compare_one_mode)
            PIRQ_CCP_CAPTURE: capture_compare_one_set = events.capture_compare_one_capture;
            PIRQ_CCP_COMPARE: capture_compare_one_set = events.capture_compare_one_match;
            default:          capture_compare_one_set = 1'b0;
        endcase

        capture_compare_two_set = 1'b0;
        case (events.capture_compare_two_mode)
            PIRQ_CCP_CAPTURE: capture_compare_two_set = events.capture_compare_two_capture;
            PIRQ_CCP_COMPARE: capture_compare_two_set = events.capture_compare_two_match;
            default:          capture_compare_two_set = 1'b0;
        endcase

        // Only the first cycle of equality counts, so a held match
        // cannot keep software from clearing the flag
        match_now = (events.timer_two_count == events.period_two);
        next_r.match_seen = match_now;

        // Flag sets ignore every enable bit
        set_one = 8'h00;
        set_one[BIT_PARALLEL]   = events.psp_access;
        set_one[BIT_CONVERSION] = events.adc_done;
        set_one[BIT_SYNC]       = sync_set;
        set_one[BIT_CCP_ONE]    = capture_compare_one_set;
        set_one[BIT_TIMER_TWO]  = match_now & ~r.match_seen;
        set_one[BIT_TIMER_ONE]  = events.timer_one_overflow;
        set_two = capture_compare_two_set;

        // Register reads see the current state
        rd_byte = 8'h00;
        case (index)
            IDX_IRQ_CONTROL:
            begin
                rd_byte[BIT_GLOBAL_EN] = r.global_en;
                rd_byte[BIT_PERIPH_EN] = r.periph_en;
            end
            IDX_EVENT_FLAGS:    rd_byte = r.event_flags;
            IDX_SECOND_FLAGS:   rd_byte = r.second_flags;
            IDX_ENABLE_BANK:    rd_byte = r.enable_bank;
            IDX_SECOND_ENABLES: rd_byte = r.second_enables;
            IDX_RESET_CAUSE:    rd_byte = r.reset_cause;
            default:            rd_byte = 8'h00;
        endcase

        // Two-cycle slave: accept, then answer with waitrequest low;
        // the write lands at the edge where the master sees the answer
        pending  = av_req.read | av_req.write;
        do_write = 1'b0;
        case (r.phase)
            PIRQ_BUS_IDLE:
            begin
                if (pending)
                begin
                    next_r.phase            = PIRQ_BUS_ANSWER;
                    next_r.rsp.waitrequest  = 1'b0;
                end
                // Read data holds until the next read, so writes keep it
                if (av_req.read)
                begin
                    next_r.rsp.readdata     = RD_ZERO;
                    next_r.rsp.readdata[7:0] = rd_byte;
                end
            end
            PIRQ_BUS_ANSWER:
            begin
                do_write               = av_req.write & lane0;
                next_r.phase           = PIRQ_BUS_IDLE;
                next_r.rsp.waitrequest = 1'b1;
            end
            default:
            begin
                next_r.phase           = PIRQ_BUS_IDLE;
                next_r.rsp.waitrequest = 1'b1;
            end
        endcase

        if (do_write)
        begin
            case (index)
                IDX_IRQ_CONTROL:
                begin
                    next_r.global_en = wbyte[BIT_GLOBAL_EN];
                    next_r.periph_en = wbyte[BIT_PERIPH_EN];
                end
                IDX_EVENT_FLAGS:
                begin
                    next_r.event_flags = (r.event_flags & ~EVENT_WRITE_MASK)
                                       | (wbyte & EVENT_WRITE_MASK);
                end
                IDX_SECOND_FLAGS:
                begin
                    next_r.second_flags = 8'h00;
                    next_r.second_flags[BIT_CCP_TWO] = wbyte[BIT_CCP_TWO];
                end
                IDX_ENABLE_BANK:    next_r.enable_bank = wbyte;
                IDX_SECOND_ENABLES:
                begin
                    next_r.second_enables = 8'h00;
                    next_r.second_enables[BIT_CCP_TWO] = wbyte[BIT_CCP_TWO];
                end
                IDX_RESET_CAUSE:
                begin
                    next_r.reset_cause = 8'h00;
                    next_r.reset_cause[BIT_POWER_ON] =
                        wbyte[BIT_POWER_ON];
                    next_r.reset_cause[BIT_BROWNOUT] =
                        wbyte[BIT_BROWNOUT];
                end
                default:
                begin
                    next_r.global_en = r.global_en;
                end
            endcase
        end

        // Hardware sets are applied after the write so they win
        next_r.event_flags = next_r.event_flags | set_one;
        next_r.event_flags[BIT_RECEIVE]  = events.rx_buffer_full;
        next_r.event_flags[BIT_TRANSMIT] = events.tx_buffer_empty;
        next_r.second_flags[BIT_CCP_TWO] =
            next_r.second_flags[BIT_CCP_TWO] | set_two;

        // With detection off the bit simply keeps what software wrote;
        // it carries no meaning then
        if (events.brownout_detected && events.brownout_circuit_enable)
        begin
            next_r.reset_cause[BIT_BROWNOUT] = 1'b0;
        end

        next_r.irq = next_r.global_en & next_r.periph_en
                   & (|(next_r.event_flags & next_r.enable_bank)
                   | (next_r.second_flags[BIT_CCP_TWO]
                      & next_r.second_enables[BIT_CCP_TWO]));
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            r.event_flags     <= RST_FLAGS;
            r.second_flags    <= RST_FLAGS;
            r.enable_bank     <= RST_ENABLES;
            r.second_enables  <= RST_ENABLES;
            r.reset_cause     <= RST_RESET_CAUSE;
            r.global_en       <= 1'b0;
            r.periph_en       <= 1'b0;
            r.match_seen      <= 1'b0;
            r.phase           <= PIRQ_BUS_IDLE;
            r.rsp.readdata    <= RD_ZERO;
            r.rsp.waitrequest <= 1'b1;
            r.irq             <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end
endmodule // pirq_top
`default_nettype wire

// ===== bench/pirq_top_monitor.sv
`default_nettype none
module pirq_top_monitor
(
    input wire logic                   clock,
    input wire logic                   nrst,
    input wire pirq_pkg::pirq_events_t events,
    input wire pirq_pkg::pirq_av_req_t av_req,
    input wire pirq_pkg::pirq_av_rsp_t av_rsp,
    input wire logic                   irq
);
    import pirq_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    logic       ack;
    logic       rd_go;
    logic [7:0] idx;
    assign ack = !av_rsp.waitrequest;
    assign idx = av_req.address[9:2];
    assign rd_go = av_req.read && !ack;
    req_answer_a: assert property ((av_req.read || av_req.write) && !ack |=> ack)
        else $error("request not answered");
    ack_single_a: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    upper_zero_a: assert property (ack |-> av_rsp.readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    second_enable_a: assert property (rd_go && idx == IDX_SECOND_ENABLES
        |=> av_rsp.readdata[7:1] == 7'h0) else $error("enable spare bits");
    second_flag_a: assert property (rd_go && idx == IDX_SECOND_FLAGS
        |=> av_rsp.readdata[7:1] == 7'h0) else $error("flag spare bits");
    cause_bits_a: assert property (rd_go && idx == IDX_RESET_CAUSE
        |=> av_rsp.readdata[7:2] == 6'h0) else $error("cause spare bits");
    buffer_level_a: assert property (rd_go && idx == IDX_EVENT_FLAGS
        && $stable(events.rx_buffer_full) && $stable(events.tx_buffer_empty)
        |=> av_rsp.readdata[5:4] ==
            {$past(events.rx_buffer_full), $past(events.tx_buffer_empty)})
        else $error("buffer flags wrong");
    rdata_hold_a: assert property (!av_req.read |=> $stable(av_rsp.readdata))
        else $error("read data moved");
    quiet_start_a: assert property ($rose(nrst) |-> !irq && !ack)
        else $error("active after reset");
endmodule // pirq_top_monitor
`default_nettype wire

// ===== bench/pirq_periph_model.sv
`default_nettype none
module pirq_periph_model
(
    input  wire logic                   clock,
    input  wire pirq_pkg::pirq_events_t cmd,
    output var  pirq_pkg::pirq_events_t events
);
    import pirq_pkg::*;
    // Peripherals launch on the clock, so a commanded pulse lasts one cycle
    always_ff @(posedge clock)
    begin
        events <= cmd;
    end
endmodule // pirq_periph_model
`default_nettype wire

// ===== bench/pirq_top_tb.sv
`default_nettype none
module pirq_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pirq_pkg::*;
    logic         clock = 1'h0;
    logic         nrst;
    pirq_events_t cmd;
    pirq_events_t base;
    pirq_events_t events;
    pirq_av_req_t av_req;
    pirq_av_rsp_t av_rsp;
    logic         irq;
    logic [31:0]  q;
    int           n_errors = 0;
    int           checked = 0;
    localparam logic [7:0] EXP_F [15] = '{8'h80, 8'h40, 8'h08, 8'h08, 8'h08,
        8'h08, 8'h08, 8'h08, 8'h04, 8'h04, 8'h00, 8'h02, 8'h01, 8'h00, 8'h00};
    always #10 clock = ~clock;
    pirq_periph_model peer (.clock(clock), .cmd(cmd), .events(events));
    pirq_top dut (.clock(clock), .nrst(nrst), .events(events),
        .av_req(av_req), .av_rsp(av_rsp), .irq(irq));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        av_req <= '{!w, w, {idx, 2'h0}, {24'h0, d}, 4'hF};
        do
        begin
            @(posedge clock);
            n++;
        end
        while (av_rsp.waitrequest !== 1'h0 && n < 20);
        if (n >= 20)
        begin
            n_errors++;
            print_verdict();
        end
        q = av_rsp.readdata;
        av_req.read <= 1'h0;
        av_req.write <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        xfer(1'h0, idx, 8'h00);
        check(q, {24'h0, e});
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'h1, idx, d);
    endtask
    task automatic fire(input pirq_events_t e);
        @(posedge clock);
        cmd <= e;
        @(posedge clock);
        cmd <= base;
    endtask
    function automatic pirq_events_t ev(input int k);
        pirq_events_t e;
        e = base;
        e.psp_access = (k == 0);
        e.adc_done = (k == 1);
        e.ssp_mode = (k < 2 || k > 7) ? PIRQ_SSP_OFF :
            (k < 5 ? pirq_ssp_mode_t'(2'(k - 2)) : PIRQ_SSP_I2C_MASTER);
        e.ssp_xfer_done = (k >= 2 && k <= 4);
        e.ssp_seq_done = (k == 5);
        e.ssp_idle = (k == 6 || k == 7);
        e.ssp_bus_start = (k == 6);
        e.ssp_bus_stop = (k == 7);
        e.capture_compare_one_mode = (k >= 8 && k <= 10) ? pirq_ccp_mode_t'(2'(k - 7)) :
            PIRQ_CCP_OFF;
        e.capture_compare_one_capture = (k == 8);
        e.capture_compare_one_match = (k == 9 || k == 10);
        e.timer_two_count = (k == 11) ? base.period_two : 8'h00;
        e.timer_one_overflow = (k == 12);
        e.capture_compare_two_mode = (k == 13 || k == 14) ? pirq_ccp_mode_t'(2'(k - 12)) :
            PIRQ_CCP_OFF;
        e.capture_compare_two_capture = (k == 13);
        e.capture_compare_two_match = (k == 14);
        e.brownout_detected = (k >= 15);
        e.brownout_circuit_enable = (k == 16);
        return e;
    endfunction
    initial
    begin
        base = '0;
        base.tx_buffer_empty = 1'h1;
        base.ssp_mode = PIRQ_SSP_OFF;
        base.period_two = 8'h05;
        cmd = base;
        av_req = '0;
        nrst = 1'h0;
        repeat (3) @(posedge clock);
        nrst <= 1'h1;
        rd(IDX_EVENT_FLAGS, 8'h10);
        rd(IDX_RESET_CAUSE, 8'h01);
        rd(IDX_ENABLE_BANK, 8'h00);
        wr(IDX_EVENT_FLAGS, 8'hFF);
        rd(IDX_EVENT_FLAGS, 8'hDF);
        wr(IDX_EVENT_FLAGS, 8'h00);
        wr(IDX_SECOND_ENABLES, 8'hFF);
        rd(IDX_SECOND_ENABLES, 8'h01);
        wr(IDX_SECOND_FLAGS, 8'hFF);
        rd(IDX_SECOND_FLAGS, 8'h01);
        wr(IDX_SECOND_FLAGS, 8'h00);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        // Enables stay off so every flag is shown to set without them
        wr(IDX_SECOND_ENABLES, 8'h00);
        for (int k = 0; k < 15; k++)
        begin
            fire(ev(k));
            rd(IDX_EVENT_FLAGS, 8'h10 | EXP_F[k]);
            rd(IDX_SECOND_FLAGS, {7'h0, k > 12});
            wr(IDX_EVENT_FLAGS, 8'h00);
            wr(IDX_SECOND_FLAGS, 8'h00);
        end
        base.rx_buffer_full = 1'h1;
        base.tx_buffer_empty = 1'h0;
        cmd <= base;
        // Levels pass the peer and the flag register before a read sees them
        repeat (2) @(posedge clock);
        rd(IDX_EVENT_FLAGS, 8'h20);
        fire(ev(15));
        rd(IDX_RESET_CAUSE, 8'h01);
        fire(ev(16));
        rd(IDX_RESET_CAUSE, 8'h00);
        wr(IDX_RESET_CAUSE, 8'hFF);
        rd(IDX_RESET_CAUSE, 8'h03);
        wr(IDX_ENABLE_BANK, 8'h01);
        wr(IDX_IRQ_CONTROL, 8'h80);
        fire(ev(12));
        rd(IDX_EVENT_FLAGS, 8'h21);
        check({31'h0, irq}, 32'h0);
        wr(IDX_IRQ_CONTROL, 8'hC0);
        rd(IDX_IRQ_CONTROL, 8'hC0);
        check({31'h0, irq}, 32'h1);
        wr(IDX_EVENT_FLAGS, 8'h00);
        rd(IDX_EVENT_FLAGS, 8'h20);
        check({31'h0, irq}, 32'h0);
        @(posedge clock);
        nrst <= 1'h0;
        repeat (3) @(posedge clock);
        nrst <= 1'h1;
        rd(IDX_RESET_CAUSE, 8'h01);
        rd(IDX_ENABLE_BANK, 8'h00);
        print_verdict();
    end
endmodule // pirq_top_tb
bind pirq_top pirq_top_monitor mon (.clock(clock), .nrst(nrst),
    .events(events), .av_req(av_req), .av_rsp(av_rsp), .irq(irq));
`default_nettype wire
